// [logic/timer_event_counter.sv]
// 8-bit timer/event counter with compare, square wave, PWM and pin direction
// Notes on behaviour
// - clear mode: count equal compare clears to zero, counts on, interrupts.
// - count clock comes from bits 0 to 2 of clock select register.
// - interval timer repeats interrupts every compare plus one count clocks.
// - mode set while stopped, enable starts; interrupts repeat until cleared.
// - event mode counts each selected rising or falling event pin edge.
// - direction bit zero drives the pin, one turns the buffer off.
// - port 3 direction keeps bits 0 to 3; bits 7 to 4 read one.
// - square mode toggles output flip-flop on each match and clears counter.
// - square frequency is one over two periods times compare plus one.
// - set and reset bits give initial high or low square level.
// - mode bit 6 selects PWM; bit 0 gates the output.
// - PWM compare sets active width; bit 1 picks active low polarity.
// - PWM inactive until first overflow, active until match, then inactive.
// - clearing enable in PWM mode drives the output inactive.
// - PWM cycle 256 count clocks, active width N, duty N over 256.
// - PWM compare written while running loads at next overflow.
// - output enable zero holds the timer output low.
// - set and reset bits are write only and read zero.
// - first match after start may come up to one count clock early.
`timescale 1ns/1ps
module timer_event_counter #(
	parameter int PIN_PORT = timer_pkg::PIN_ON_PORT1
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic eventPin,
	output logic timerPinOut,
	output logic timerPinOe,
	output logic matchIrq,
	output logic [7:0] port1Dir,
	output logic [timer_pkg::PORT3_DIR_W-1:0] port3Dir
);
	import timer_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [7:0] count_q, count_d;
	logic [7:0] cmpBuf_q, cmpBuf_d;
	logic [7:0] cmpAct_q, cmpAct_d;
	logic [2:0] clkSel_q, clkSel_d;
	logic enable_q, enable_d;
	logic pwm_q, pwm_d;
	logic pol_q, pol_d;
	logic oe_q, oe_d;
	logic ff_q, ff_d;
	pwmPhase_t phase_q, phase_d;
	logic irq_q, irq_d;
	logic out_q, out_d;
	logic pinOe_q, pinOe_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] p1Dir_q, p1Dir_d;
	logic [PORT3_DIR_W-1:0] p3Dir_q, p3Dir_d;
	logic tick;
	logic wrMode, wrSel, wrCmp;

	function automatic logic pinLevel(input logic oe, input logic pwm,
		input pwmPhase_t ph, input logic pol, input logic ff);
		if (!oe)
			pinLevel = 1'b0;
		else if (pwm)
			pinLevel = (ph == PH_ACTIVE) ^ pol;
		else
			pinLevel = ff;
	endfunction

	// ------------------------------------------------------------------
	// count clock
	// ------------------------------------------------------------------
	count_tick_gen u_tick (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.clkSel(clkSel_q),
		.eventPin(eventPin),
		.tick(tick)
	);

	assign wrMode = regWr && (regAddr == ADDR_MODE_CTRL);
	assign wrSel = regWr && (regAddr == ADDR_CLK_SEL);
	assign wrCmp = regWr && (regAddr == ADDR_COMPARE);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		count_d = count_q;
		cmpBuf_d = cmpBuf_q;
		cmpAct_d = cmpAct_q;
		clkSel_d = clkSel_q;
		enable_d = enable_q;
		pwm_d = pwm_q;
		pol_d = pol_q;
		oe_d = oe_q;
		ff_d = ff_q;
		phase_d = phase_q;
		irq_d = 1'b0;
		p1Dir_d = p1Dir_q;
		p3Dir_d = p3Dir_q;
		rdata_d = rdata_q;

		// counting; prescaler runs free, so start is not aligned
		if (enable_q && tick) begin
			if (pwm_q) begin
				count_d = count_q + 8'h01;
				if (count_q == COUNT_MAX) begin
					cmpAct_d = cmpBuf_q;
					phase_d = (cmpBuf_q == 8'h00) ? PH_IDLE : PH_ACTIVE;
				end else if (phase_q == PH_ACTIVE && count_d == cmpAct_q) begin
					phase_d = PH_IDLE;
					irq_d = 1'b1;
				end
			end else if (count_q == cmpAct_q) begin
				count_d = 8'h00;
				irq_d = 1'b1;
				if (pol_q)
					ff_d = ~ff_q;
			end else begin
				count_d = count_q + 8'h01;
			end
		end

		// register writes
		if (wrMode) begin
			enable_d = regWdata[MODE_ENABLE_BIT];
			pwm_d = regWdata[MODE_PWM_BIT];
			pol_d = regWdata[MODE_POL_BIT];
			oe_d = regWdata[MODE_OE_BIT];
			if (!regWdata[MODE_PWM_BIT]) begin
				if (regWdata[MODE_SET_BIT] && !regWdata[MODE_RESET_BIT])
					ff_d = 1'b1;
				else if (regWdata[MODE_RESET_BIT] && !regWdata[MODE_SET_BIT])
					ff_d = 1'b0;
			end
		end
		if (wrSel)
			clkSel_d = regWdata[CLK_SEL_LSB +: CLK_SEL_W];
		if (wrCmp) begin
			cmpBuf_d = regWdata;
			if (!pwm_q || !enable_q)
				cmpAct_d = regWdata;
		end
		if (regWr && regAddr == ADDR_PORT1_DIR)
			p1Dir_d = regWdata;
		if (regWr && regAddr == ADDR_PORT3_DIR)
			p3Dir_d = regWdata[PORT3_DIR_W-1:0];

		// stopped counter is held cleared
		if (!enable_d) begin
			count_d = 8'h00;
			phase_d = PH_WAIT;
		end

		if (regRd) begin
			unique case (regAddr)
				ADDR_PORT1_DIR: rdata_d = p1Dir_q;
				ADDR_PORT3_DIR: rdata_d = {PORT3_FIXED_HIGH, p3Dir_q};
				ADDR_MODE_CTRL: rdata_d = {enable_q, pwm_q, 4'h0, pol_q,
					oe_q};
				ADDR_CLK_SEL: rdata_d = {5'h00, clkSel_q};
				ADDR_COMPARE: rdata_d = cmpBuf_q;
				default: rdata_d = 8'h00;
			endcase
		end

		out_d = pinLevel(oe_d, pwm_d, phase_d, pol_d, ff_d);
		if (PIN_PORT == PIN_ON_PORT3)
			pinOe_d = ~p3Dir_d[PORT3_TIMER_BIT];
		else
			pinOe_d = ~p1Dir_d[PORT1_TIMER_BIT];
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			count_q <= RST_TIMER_REG;
			cmpBuf_q <= RST_TIMER_REG;
			cmpAct_q <= RST_TIMER_REG;
			clkSel_q <= 3'h0;
			enable_q <= 1'b0;
			pwm_q <= 1'b0;
			pol_q <= 1'b0;
			oe_q <= 1'b0;
			ff_q <= 1'b0;
			phase_q <= PH_WAIT;
			irq_q <= 1'b0;
			out_q <= 1'b0;
			pinOe_q <= 1'b0;
			rdata_q <= 8'h00;
			p1Dir_q <= RST_PORT_DIR;
			p3Dir_q <= PORT3_FIXED_HIGH;
		end else if (ce) begin
			count_q <= count_d;
			cmpBuf_q <= cmpBuf_d;
			cmpAct_q <= cmpAct_d;
			clkSel_q <= clkSel_d;
			enable_q <= enable_d;
			pwm_q <= pwm_d;
			pol_q <= pol_d;
			oe_q <= oe_d;
			ff_q <= ff_d;
			phase_q <= phase_d;
			irq_q <= irq_d;
			out_q <= out_d;
			pinOe_q <= pinOe_d;
			rdata_q <= rdata_d;
			p1Dir_q <= p1Dir_d;
			p3Dir_q <= p3Dir_d;
		end
	end

	assign regRdata = rdata_q;
	assign timerPinOut = out_q;
	assign timerPinOe = pinOe_q;
	assign matchIrq = irq_q;
	assign port1Dir = p1Dir_q;
	assign port3Dir = p3Dir_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	clear_on_match_a: assert property (
		ce && enable_q && !pwm_q && tick && count_q == cmpAct_q && !wrMode
		|=> count_q == 8'h00 && matchIrq)
		else $error("clear mode match did not clear and interrupt");

	stop_holds_zero_a: assert property (
		ce && !enable_d |=> count_q == 8'h00)
		else $error("stopped counter not cleared");

	square_toggle_a: assert property (
		ce && enable_q && !pwm_q && pol_q && tick && count_q == cmpAct_q
		&& !wrMode |=> ff_q != $past(ff_q))
		else $error("square output did not toggle on match");

	port3_upper_a: assert property (
		ce && regRd && regAddr == ADDR_PORT3_DIR |=> regRdata[7:4] == 4'hF)
		else $error("port 3 upper direction bits not one");

	mode_read_zero_a: assert property (
		ce && regRd && regAddr == ADDR_MODE_CTRL |=> regRdata[3:2] == 2'b00)
		else $error("set and reset bits read nonzero");

	output_off_low_a: assert property (
		ce && !oe_d |=> !timerPinOut)
		else $error("disabled output not low");

	pwm_stop_idle_a: assert property (
		ce && pwm_d && oe_d && !enable_d |=> timerPinOut == $past(pol_d))
		else $error("stopped pwm output not inactive");

	pwm_overflow_load_a: assert property (
		ce && enable_q && pwm_q && tick && count_q == COUNT_MAX && !wrMode
		|=> cmpAct_q == $past(cmpBuf_q) && count_q == 8'h00)
		else $error("pwm overflow did not load compare");

	pin_dir_a: assert property (
		ce && regWr && regAddr == ADDR_PORT1_DIR && PIN_PORT == PIN_ON_PORT1
		|=> timerPinOe == !$past(regWdata[7]))
		else $error("pin enable does not follow direction bit");

	pwm_match_idle_a: assert property (
		ce && enable_q && pwm_q && tick && count_q != COUNT_MAX
		&& phase_q == PH_ACTIVE && count_d == cmpAct_q && !wrMode
		|=> phase_q == PH_IDLE && matchIrq)
		else $error("pwm active width did not end at match");

	pwm_wrap_active_a: assert property (
		ce && enable_q && pwm_q && tick && count_q == COUNT_MAX
		&& cmpBuf_q != 8'h00 && !wrMode |=> phase_q == PH_ACTIVE)
		else $error("pwm output not active after overflow");

	pwm_first_wait_a: assert property (
		ce && phase_q == PH_WAIT && !(tick && count_q == COUNT_MAX)
		|=> phase_q == PH_WAIT)
		else $error("pwm left waiting phase without overflow");

	event_step_a: assert property (
		ce && enable_q && !pwm_q && tick && count_q != cmpAct_q && !wrMode
		|=> count_q == $past(count_q) + 8'h01)
		else $error("counter did not step on count clock");

	no_tick_hold_a: assert property (
		ce && enable_q && !tick && !wrMode |=> count_q == $past(count_q))
		else $error("counter moved without count clock");

	port3_write_a: assert property (
		ce && regWr && regAddr == ADDR_PORT3_DIR
		|=> port3Dir == $past(regWdata[3:0]))
		else $error("port 3 direction write not taken");

endmodule

// [logic/timer_pkg.sv]
// constants for the 8-bit timer/event counter and its port direction bits
package timer_pkg;

	// ------------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------------
	localparam logic [15:0] ADDR_PORT1_DIR = 16'hFF21;
	localparam logic [15:0] ADDR_PORT3_DIR = 16'hFF23;
	localparam logic [15:0] ADDR_MODE_CTRL = 16'hFF43;
	localparam logic [15:0] ADDR_CLK_SEL = 16'hEE8C;
	localparam logic [15:0] ADDR_COMPARE = 16'hFF42;

	// ------------------------------------------------------------------
	// field positions of the mode control and clock select registers, and port 3 direction width
	// ------------------------------------------------------------------
	localparam int MODE_ENABLE_BIT = 7;
	localparam int MODE_PWM_BIT = 6;
	localparam int MODE_SET_BIT = 3;
	localparam int MODE_RESET_BIT = 2;
	localparam int MODE_POL_BIT = 1;
	localparam int MODE_OE_BIT = 0;
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_SEL_W = 3;
	localparam int PORT3_DIR_W = 4;

	// ------------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_PORT_DIR = 8'hFF;
	localparam logic [7:0] RST_TIMER_REG = 8'h00;
	localparam logic [3:0] PORT3_FIXED_HIGH = 4'hF;

	// ------------------------------------------------------------------
	// count clock selection codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SEL_EDGE_FALL = 3'h0;
	localparam logic [2:0] SEL_EDGE_RISE = 3'h1;
	localparam logic [2:0] SEL_DIV1 = 3'h2;
	localparam logic [2:0] SEL_DIV2 = 3'h3;
	localparam logic [2:0] SEL_DIV16 = 3'h4;
	localparam logic [2:0] SEL_DIV64 = 3'h5;
	localparam logic [2:0] SEL_DIV256 = 3'h6;
	localparam logic [2:0] SEL_DIV4096 = 3'h7;
	localparam int PRESCALE_W = 12;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

	// pin that carries the timer output: 0 = port 1 bit 7, 1 = port 3 bit 3
	localparam int PIN_ON_PORT1 = 0;
	localparam int PIN_ON_PORT3 = 1;
	localparam int PORT1_TIMER_BIT = 7;
	localparam int PORT3_TIMER_BIT = 3;

	typedef enum logic [1:0] {PH_WAIT, PH_ACTIVE, PH_IDLE} pwmPhase_t;

endpackage

// [logic/count_tick_gen.sv]
// count clock generator: prescaled main clock or event pin edge
`timescale 1ns/1ps
module count_tick_gen (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [2:0] clkSel,
	input wire logic eventPin,
	output logic tick
);
	import timer_pkg::*;

	logic [PRESCALE_W-1:0] pre_q, pre_d;
	logic prev_q, prev_d;
	logic tick_q, tick_d;

	function automatic logic [PRESCALE_W-1:0] divMask(input logic [2:0] s);
		unique case (s)
			SEL_DIV2: divMask = 12'h001;
			SEL_DIV16: divMask = 12'h00F;
			SEL_DIV64: divMask = 12'h03F;
			SEL_DIV256: divMask = 12'h0FF;
			SEL_DIV4096: divMask = 12'hFFF;
			default: divMask = 12'h000;
		endcase
	endfunction

	always_comb begin
		pre_d = pre_q + 12'h001;
		prev_d = eventPin;
		unique case (clkSel)
			SEL_EDGE_FALL: tick_d = prev_q & ~eventPin;
			SEL_EDGE_RISE: tick_d = ~prev_q & eventPin;
			default: tick_d = ((pre_q & divMask(clkSel)) == 12'h000);
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pre_q <= '0;
			prev_q <= 1'b0;
			tick_q <= 1'b0;
		end else if (ce) begin
			pre_q <= pre_d;
			prev_q <= prev_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule

// [tb/pulse_source.sv]
// far-side model: event pulse source and timer pin load
`timescale 1ns/1ps
module pulse_source (
	input wire logic clk_sys,
	input wire logic pinOut,
	input wire logic pinOe,
	output logic eventPin,
	output logic pinLevel
);
	// ---------------------------------
	// pin load with pull-down
	// ---------------------------------
	assign pinLevel = pinOe ? pinOut : 1'b0;
	initial eventPin = 1'b0;
	// each pulse gives one rising and one falling edge
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			eventPin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			eventPin <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
	endtask
endmodule

// [tb/test_timer_event_counter.sv]
// self-checking bench for the timer/event counter
`timescale 1ns/1ps
module test_timer_event_counter;
	import timer_pkg::*;
	logic clk_sys, nrst, ce, regWr, regRd, eventPin, pinLevel;
	logic timerPinOut, timerPinOe, matchIrq;
	logic [15:0] regAddr;
	logic [7:0] regWdata, regRdata, port1Dir, got;
	logic [3:0] port3Dir;
	int fails = 0;
	int tests_run = 0;
	int irqCnt = 0;
	int n, k;
	// ---------------------------------
	// design and far side
	// ---------------------------------
	timer_event_counter i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .eventPin(eventPin),
		.timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
		.matchIrq(matchIrq), .port1Dir(port1Dir), .port3Dir(port3Dir));
	pulse_source i_src (.clk_sys(clk_sys), .pinOut(timerPinOut),
		.pinOe(timerPinOe), .eventPin(eventPin), .pinLevel(pinLevel));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (matchIrq === 1'b1) irqCnt++;
	end
	// ---------------------------------
	// access and compare tasks
	// ---------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 got = regRdata;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkn(input int g, input int e);
		tests_run++;
		if (g != e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// cycles until the next interrupt sample
	task automatic waitIrq(output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			#1 c++;
		end while (matchIrq !== 1'b1 && c < 2000);
	endtask
	// length of the next run of the pin at level lvl
	task automatic runLen(input logic lvl, output int len);
		int w;
		w = 0;
		len = 0;
		#1;
		while (pinLevel !== lvl && w < 2000) begin
			@(posedge clk_sys);
			#1 w++;
		end
		while (pinLevel === lvl && len < 2000) begin
			@(posedge clk_sys);
			#1 len++;
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#300000;
		fails++;
		give_verdict;
	end
	// ---------------------------------
	// tests
	// ---------------------------------
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 16'h0000;
		regWdata = 8'h00;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(ADDR_PORT1_DIR);
		chk(got, 8'hFF);
		rd(ADDR_PORT3_DIR);
		chk(got, 8'hFF);
		wr(ADDR_PORT3_DIR, 8'h00);
		rd(ADDR_PORT3_DIR);
		chk(got, 8'hF0);
		chk({4'h0, port3Dir}, 8'h00);
		rd(16'h1234);
		chk(got, 8'h00);
		// interval timer on the main clock
		wr(ADDR_CLK_SEL, 8'h02);
		wr(ADDR_COMPARE, 8'h04);
		wr(ADDR_MODE_CTRL, 8'h00);
		wr(ADDR_MODE_CTRL, 8'h80);
		waitIrq(n);
		waitIrq(n);
		chkn(n, 5);
		waitIrq(n);
		chkn(n, 5);
		wr(ADDR_MODE_CTRL, 8'h00);
		k = irqCnt;
		repeat (20) @(posedge clk_sys);
		chkn(irqCnt, k);
		// square wave, initial high then toggling
		wr(ADDR_PORT1_DIR, 8'h7F);
		ce <= 1'b0;
		wr(ADDR_PORT1_DIR, 8'h00);
		ce <= 1'b1;
		#1 chk(port1Dir, 8'h7F);
		chk({7'h00, timerPinOe}, 8'h01);
		wr(ADDR_COMPARE, 8'h03);
		wr(ADDR_MODE_CTRL, 8'h0B);
		rd(ADDR_MODE_CTRL);
		chk(got, 8'h03);
		chk({7'h00, pinLevel}, 8'h01);
		wr(ADDR_MODE_CTRL, 8'h83);
		runLen(1'b0, n);
		chkn(n, 4);
		runLen(1'b1, n);
		chkn(n, 4);
		wr(ADDR_MODE_CTRL, 8'h07);
		#1 chk({7'h00, pinLevel}, 8'h00);
		// pwm, then a compare change taken at the wrap
		wr(ADDR_MODE_CTRL, 8'h41);
		wr(ADDR_COMPARE, 8'h40);
		wr(ADDR_MODE_CTRL, 8'hC1);
		runLen(1'b1, n);
		chkn(n, 64);
		fork
			runLen(1'b0, n);
			wr(ADDR_COMPARE, 8'h20);
		join
		chkn(n, 192);
		runLen(1'b1, n);
		chkn(n, 32);
		runLen(1'b0, n);
		chkn(n, 224);
		wr(ADDR_MODE_CTRL, 8'h41);
		#1 chk({7'h00, pinLevel}, 8'h00);
		wr(ADDR_MODE_CTRL, 8'h43);
		#1 chk({7'h00, pinLevel}, 8'h01);
		wr(ADDR_MODE_CTRL, 8'h42);
		#1 chk({7'h00, pinLevel}, 8'h00);
		// event counting on both edges
		wr(ADDR_MODE_CTRL, 8'h00);
		wr(ADDR_PORT1_DIR, 8'hFF);
		#1 chk({7'h00, timerPinOe}, 8'h00);
		wr(ADDR_COMPARE, 8'h02);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_MODE_CTRL, 8'h00);
			wr(ADDR_CLK_SEL, 8'(s));
			wr(ADDR_MODE_CTRL, 8'h80);
			k = irqCnt;
			i_src.pulse(2);
			chkn(irqCnt - k, 0);
			i_src.pulse(1);
			chkn(irqCnt - k, 1);
		end
		give_verdict;
	end
endmodule
